// File: rtl/bsp_tap.sv
// Boundary-scan test access port with boundary register over NPINS pins.
// Assumes tck from the external controller; programming status comes from sys_clk logic.
// Functional notes
// - Test port runs from power-up; no input disables it.
// - From reset, mode-select 0,1,1,0,0 reaches instruction shift.
// - Instruction shift first presents captured ten-bit pattern 1010101010.
// - Under external test, enable cell 0 drives output-data cell onto pin.
// - External-test and sample refused while in-system programming runs.
// - Output-only pins have input buffers off unless keep setting set.
// - All-ones instruction selects one-bit bypass.
// - Data shift samples input on rise, changes output on fall.
// - Two high mode-select cycles leave data shift to update.
`timescale 1ns/100ps
`include "bsp_map.svh"
module bsp_tap #(
	parameter int NPINS = 4
) (
	// System side.
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic             isp_busy,
	input  wire logic [NPINS-1:0] out_only,
	input  wire logic             keep_in_buf,
	input  wire logic [NPINS-1:0] core_out,
	input  wire logic [NPINS-1:0] core_oe,
	// Test link.
	input  wire logic             tck,
	input  wire bsp_pkg::bsp_tap_in_t tap_in,
	output logic                  tdo,
	output logic                  tdo_oe,
	// Pins.
	input  wire logic [NPINS-1:0] pin_level,
	output logic [NPINS-1:0]      pin_data,
	output logic [NPINS-1:0]      pin_oe,
	output logic [NPINS-1:0]      in_buf_en
);
	localparam int BW = 2 * NPINS;
	bsp_pkg::bsp_state_t st_r;
	bsp_pkg::bsp_state_t st_nxt;
	logic [`BSP_IR_W-1:0] ir_sh_r;
	logic [`BSP_IR_W-1:0] ir_r;
	logic [BW-1:0]        bs_sh_r;
	logic [NPINS-1:0]     upd_out_r;
	logic [NPINS-1:0]     upd_oe_r;
	logic                 byp_r;
	logic                 isp_m1_r;
	logic                 isp_s_r;
	logic                 tdo_nxt;
	logic                 sel_byp;
	logic [`BSP_IR_W-1:0] ir_nxt;
	logic                 ext_r;
	logic [3*NPINS-1:0]   smp_s1_r;
	logic [3*NPINS-1:0]   smp_s_r;
	logic                 ext_m1_r;
	logic                 ext_s_r;
	logic                 upd_tgl_r;
	logic                 tgl_m1_r;
	logic                 tgl_s_r;
	logic                 tgl_d_r;
	logic [NPINS-1:0]     upo_s_r;
	logic [NPINS-1:0]     upe_s_r;

	// Programming status crosses into the test-clock domain on two flops.
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			isp_m1_r <= 1'b0;
			isp_s_r  <= 1'b0;
		end else begin
			isp_m1_r <= isp_busy;
			isp_s_r  <= isp_m1_r;
		end
	end

	// Next controller state from sampled mode select.
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			bsp_pkg::BSP_TLR:  st_nxt = tap_in.tms ? bsp_pkg::BSP_TLR  : bsp_pkg::BSP_RTI;
			bsp_pkg::BSP_RTI:  st_nxt = tap_in.tms ? bsp_pkg::BSP_SDRS : bsp_pkg::BSP_RTI;
			bsp_pkg::BSP_SDRS: st_nxt = tap_in.tms ? bsp_pkg::BSP_SIRS : bsp_pkg::BSP_CDR;
			bsp_pkg::BSP_CDR:  st_nxt = tap_in.tms ? bsp_pkg::BSP_E1DR : bsp_pkg::BSP_SDR;
			bsp_pkg::BSP_SDR:  st_nxt = tap_in.tms ? bsp_pkg::BSP_E1DR : bsp_pkg::BSP_SDR;
			bsp_pkg::BSP_E1DR: st_nxt = tap_in.tms ? bsp_pkg::BSP_UDR  : bsp_pkg::BSP_PDR;
			bsp_pkg::BSP_PDR:  st_nxt = tap_in.tms ? bsp_pkg::BSP_E2DR : bsp_pkg::BSP_PDR;
			bsp_pkg::BSP_E2DR: st_nxt = tap_in.tms ? bsp_pkg::BSP_UDR  : bsp_pkg::BSP_SDR;
			bsp_pkg::BSP_UDR:  st_nxt = tap_in.tms ? bsp_pkg::BSP_SDRS : bsp_pkg::BSP_RTI;
			bsp_pkg::BSP_SIRS: st_nxt = tap_in.tms ? bsp_pkg::BSP_TLR  : bsp_pkg::BSP_CIR;
			bsp_pkg::BSP_CIR:  st_nxt = tap_in.tms ? bsp_pkg::BSP_E1IR : bsp_pkg::BSP_SIR;
			bsp_pkg::BSP_SIR:  st_nxt = tap_in.tms ? bsp_pkg::BSP_E1IR : bsp_pkg::BSP_SIR;
			bsp_pkg::BSP_E1IR: st_nxt = tap_in.tms ? bsp_pkg::BSP_UIR  : bsp_pkg::BSP_PIR;
			bsp_pkg::BSP_PIR:  st_nxt = tap_in.tms ? bsp_pkg::BSP_E2IR : bsp_pkg::BSP_PIR;
			bsp_pkg::BSP_E2IR: st_nxt = tap_in.tms ? bsp_pkg::BSP_UIR  : bsp_pkg::BSP_SIR;
			bsp_pkg::BSP_UIR:  st_nxt = tap_in.tms ? bsp_pkg::BSP_SDRS : bsp_pkg::BSP_RTI;
		endcase
	end

	// Controller advances on every rising test clock, enabled from power-up.
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			st_r <= bsp_pkg::BSP_TLR;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Instruction shift register captures the fixed pattern, then shifts.
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			ir_sh_r <= `BSP_IR_CAPTURE;
		end else if (st_r == bsp_pkg::BSP_CIR) begin
			ir_sh_r <= `BSP_IR_CAPTURE;
		end else if (st_r == bsp_pkg::BSP_SIR) begin
			ir_sh_r <= {tap_in.tdi, ir_sh_r[`BSP_IR_W-1:1]};
		end
	end

	// Next instruction; sample and external test refused during programming.
	always_comb begin
		ir_nxt = ir_r;
		if (st_r == bsp_pkg::BSP_TLR) begin
			ir_nxt = `BSP_IR_RESET;
		end else if (st_r == bsp_pkg::BSP_UIR) begin
			ir_nxt = ir_sh_r;
		end
		if (isp_s_r && (ir_nxt == `BSP_IR_SAMPLE || ir_nxt == `BSP_IR_EXTEST)) begin
			ir_nxt = `BSP_IR_BYPASS;
		end
	end

	// Instruction and its pin-mode decode load together, so the mode bit
	// that crosses to the system clock is a flop output and cannot glitch.
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			ir_r  <= `BSP_IR_RESET;
			ext_r <= 1'b0;
		end else begin
			ir_r  <= ir_nxt;
			ext_r <= (ir_nxt == `BSP_IR_EXTEST) || (ir_nxt == `BSP_IR_CLAMP);
		end
	end

	// Boundary register data path selection.
	assign sel_byp = !(ir_r == `BSP_IR_SAMPLE || ir_r == `BSP_IR_EXTEST);

	// Bypass bit clears on capture and shifts on the rising edge.
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			byp_r <= 1'b0;
		end else if (st_r == bsp_pkg::BSP_CDR) begin
			byp_r <= 1'b0;
		end else if (st_r == bsp_pkg::BSP_SDR) begin
			byp_r <= tap_in.tdi;
		end
	end

	// Boundary shift register: pin levels and enables captured, then shifted.
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			bs_sh_r <= '0;
		end else if (st_r == bsp_pkg::BSP_CDR && !sel_byp) begin
			bs_sh_r <= {smp_s_r[3*NPINS-1:2*NPINS],
				smp_s_r[NPINS-1:0] & smp_s_r[2*NPINS-1:NPINS]};
		end else if (st_r == bsp_pkg::BSP_SDR && !sel_byp) begin
			bs_sh_r <= {tap_in.tdi, bs_sh_r[BW-1:1]};
		end
	end

	// Update cells load on data update; enable cell is active low.
	// The toggle tells the system clock that new cell contents stand.
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			upd_out_r <= '0;
			upd_oe_r  <= '1;
			upd_tgl_r <= 1'b0;
		end else if (st_r == bsp_pkg::BSP_UDR && !sel_byp) begin
			upd_out_r <= bs_sh_r[NPINS-1:0];
			upd_oe_r  <= bs_sh_r[BW-1:NPINS];
			upd_tgl_r <= ~upd_tgl_r;
		end
	end

	// Serial output source for the falling edge.
	always_comb begin
		tdo_nxt = 1'b0;
		if (st_r == bsp_pkg::BSP_SIR) begin
			tdo_nxt = ir_sh_r[0];
		end else if (st_r == bsp_pkg::BSP_SDR) begin
			tdo_nxt = sel_byp ? byp_r : bs_sh_r[0];
		end
	end

	// Serial output changes on the falling edge only.
	always_ff @(negedge tck or negedge rstn) begin
		if (!rstn) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo    <= tdo_nxt;
			tdo_oe <= (st_r == bsp_pkg::BSP_SIR) || (st_r == bsp_pkg::BSP_SDR);
		end
	end

	// Pin levels, enables and buffer gates enter the test-clock domain on two
	// flops; they are levels that stand still while a capture is taken.
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			smp_s1_r <= '0;
			smp_s_r  <= '0;
		end else begin
			smp_s1_r <= {pin_oe, in_buf_en, pin_level};
			smp_s_r  <= smp_s1_r;
		end
	end

	// Mode bit crosses on two flops; the update-cell words follow a toggle.
	// The words stand still from the toggle until the next data update, so
	// updates must lie at least four system clocks apart.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ext_m1_r <= 1'b0;
			ext_s_r  <= 1'b0;
			tgl_m1_r <= 1'b0;
			tgl_s_r  <= 1'b0;
			tgl_d_r  <= 1'b0;
			upo_s_r  <= '0;
			upe_s_r  <= '1;
		end else begin
			ext_m1_r <= ext_r;
			ext_s_r  <= ext_m1_r;
			tgl_m1_r <= upd_tgl_r;
			tgl_s_r  <= tgl_m1_r;
			tgl_d_r  <= tgl_s_r;
			if (tgl_s_r != tgl_d_r) begin
				upo_s_r <= upd_out_r;
				upe_s_r <= upd_oe_r;
			end
		end
	end

	// Pin drivers: update cells in external test or clamp, core otherwise.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pin_data  <= '0;
			pin_oe    <= '0;
			in_buf_en <= '0;
		end else begin
			pin_data  <= ext_s_r ? upo_s_r : core_out;
			pin_oe    <= ext_s_r ? ~upe_s_r : core_oe;
			in_buf_en <= keep_in_buf ? '1 : ~out_only;
		end
	end

	// Assertions on the test-clock and system-clock domains.
	sequence s_ir_entry;
		!tap_in.tms ##1 tap_in.tms ##1 tap_in.tms ##1 !tap_in.tms ##1 !tap_in.tms;
	endsequence

	sequence s_dr_exit;
		tap_in.tms ##1 tap_in.tms;
	endsequence

	a_port_awake: assert property (@(posedge tck) disable iff (!rstn)
		(st_r == bsp_pkg::BSP_TLR) && !tap_in.tms |=> (st_r == bsp_pkg::BSP_RTI))
		else $error("Test port did not leave test-logic-reset.");

	a_ir_entry_path: assert property (@(posedge tck) disable iff (!rstn)
		(st_r == bsp_pkg::BSP_TLR) ##0 s_ir_entry |=> (st_r == bsp_pkg::BSP_SIR))
		else $error("Instruction shift not reached after 01100.");

	a_dr_exit_upd: assert property (@(posedge tck) disable iff (!rstn)
		(st_r == bsp_pkg::BSP_SDR) ##0 s_dr_exit |=> (st_r == bsp_pkg::BSP_UDR))
		else $error("Data update not reached after two high cycles.");

	a_ir_capture_pat: assert property (@(posedge tck) disable iff (!rstn)
		(st_r == bsp_pkg::BSP_CIR) |=> (ir_sh_r == `BSP_IR_CAPTURE))
		else $error("Instruction capture pattern wrong.");

	a_tdo_first_bit: assert property (@(negedge tck) disable iff (!rstn)
		($rose(st_r == bsp_pkg::BSP_SIR)) |-> ##1 (tdo == 1'b0))
		else $error("First shifted instruction bit wrong.");

	a_isp_refuse: assert property (@(posedge tck) disable iff (!rstn)
		isp_s_r && $past(isp_s_r) |-> !(ir_r == `BSP_IR_SAMPLE || ir_r == `BSP_IR_EXTEST))
		else $error("Sample or external test active during programming.");

	a_tlr_reset: assert property (@(posedge tck) disable iff (!rstn)
		tap_in.tms [*5] |=> (st_r == bsp_pkg::BSP_TLR))
		else $error("Five high mode-select cycles did not reset.");

	a_bypass_pass: assert property (@(posedge tck) disable iff (!rstn)
		(st_r == bsp_pkg::BSP_SDR) && (ir_r == `BSP_IR_BYPASS) |=> (byp_r == $past(tap_in.tdi)))
		else $error("Bypass bit did not take serial input.");

	a_ext_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
		ext_s_r && !upe_s_r[0] |=> pin_oe[0] && (pin_data[0] == $past(upo_s_r[0])))
		else $error("External test did not drive update data.");

	a_upd_cross: assert property (@(posedge sys_clk) disable iff (!rstn)
		(tgl_s_r != tgl_d_r) |=> (upo_s_r == $past(upd_out_r)))
		else $error("Update cell word not taken on toggle.");

	a_inbuf_off: assert property (@(posedge sys_clk) disable iff (!rstn)
		out_only[0] && !keep_in_buf |=> !in_buf_en[0])
		else $error("Output-only pin input buffer left on.");
endmodule

// File: rtl/bsp_map.svh
// Constants for the boundary-scan test port: instruction codes, widths, reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef BSP_MAP_SVH
`define BSP_MAP_SVH
`define BSP_IR_W        10
`define BSP_IR_CAPTURE  10'h2AA
`define BSP_IR_BYPASS   10'h3FF
`define BSP_IR_SAMPLE   10'h005
`define BSP_IR_EXTEST   10'h00F
`define BSP_IR_CLAMP    10'h00A
`define BSP_IR_HIGHZ    10'h00B
`define BSP_IR_RESET    10'h3FF
`endif

// File: rtl/bsp_pkg.sv
// Types for the boundary-scan test port.
// Assumes bsp_map.svh is on the include path.
`include "bsp_map.svh"
package bsp_pkg;
	typedef enum logic [3:0] {
		BSP_TLR  = 4'h0,
		BSP_RTI  = 4'h1,
		BSP_SDRS = 4'h2,
		BSP_CDR  = 4'h3,
		BSP_SDR  = 4'h4,
		BSP_E1DR = 4'h5,
		BSP_PDR  = 4'h6,
		BSP_E2DR = 4'h7,
		BSP_UDR  = 4'h8,
		BSP_SIRS = 4'h9,
		BSP_CIR  = 4'hA,
		BSP_SIR  = 4'hB,
		BSP_E1IR = 4'hC,
		BSP_PIR  = 4'hD,
		BSP_E2IR = 4'hE,
		BSP_UIR  = 4'hF
	} bsp_state_t;
	// Test pins from the controller.
	typedef struct packed {
		logic tms;
		logic tdi;
	} bsp_tap_in_t;
endpackage

// File: verification/bsp_ctl_model.sv
// Behavioural test controller that drives the test link of the port.
// Assumes the port samples mode-select and data on the rising test clock.
`timescale 1ns/100ps
module bsp_ctl_model (
	// Test link.
	output logic                 tck,
	output bsp_pkg::bsp_tap_in_t tap_in,
	input  wire logic            tdo,
	input  wire logic            tdo_oe
);
	logic seen;
	// The clock stands low between frames and pins start idle high.
	initial begin
		tck = 1'b0;
		tap_in = 2'b11;
	end
	// One pulse: pins change after the fall, output is taken at the rise.
	// A released serial output reads as its inverse, so a missing enable shows.
	task automatic cyc(input logic ms, input logic di);
		tap_in.tms = ms;
		tap_in.tdi = di;
		#3 tck = 1'b1;
		seen = tdo_oe ? tdo : ~tdo;
		#3 tck = 1'b0;
	endtask
	// Walks from idle into a shift state, scans n bits and returns to idle.
	task automatic scan(input logic ir, input int n, input logic [15:0] din,
		output logic [15:0] dout);
		dout = '0;
		cyc(1'b1, ~tap_in.tdi);
		if (ir) begin
			cyc(1'b1, ~tap_in.tdi);
		end
		cyc(1'b0, ~tap_in.tdi);
		cyc(1'b0, ~tap_in.tdi);
		for (int i = 0; i < n; i++) begin
			cyc(i == n - 1, din[i]);
			dout[i] = seen;
		end
		cyc(1'b1, ~tap_in.tdi);
		cyc(1'b0, ~tap_in.tdi);
	endtask
endmodule

// File: verification/boundary_scan_tap_usage_tb_top.sv
// Self-checking bench for the boundary-scan test port.
// Assumes the controller model drives the test link; the bench drives the system side.
`timescale 1ns/100ps
`include "bsp_map.svh"
module boundary_scan_tap_usage_tb_top;
	localparam int NPINS = 4;
	logic                 sys_clk;
	logic                 rstn;
	logic                 isp_busy;
	logic                 keep_in_buf;
	logic                 tck;
	logic                 tdo;
	logic                 tdo_oe;
	logic [NPINS-1:0]     out_only;
	logic [NPINS-1:0]     core_out;
	logic [NPINS-1:0]     core_oe;
	logic [NPINS-1:0]     pin_level;
	logic [NPINS-1:0]     pin_data;
	logic [NPINS-1:0]     pin_oe;
	logic [NPINS-1:0]     in_buf_en;
	logic [15:0]          got;
	bsp_pkg::bsp_tap_in_t tap_in;
	int                   fail_count = 0;
	int                   total_checks = 0;

	bsp_tap #(.NPINS(NPINS)) bsp_tap_inst (.sys_clk(sys_clk), .rstn(rstn),
		.isp_busy(isp_busy), .out_only(out_only), .keep_in_buf(keep_in_buf),
		.core_out(core_out), .core_oe(core_oe), .tck(tck), .tap_in(tap_in),
		.tdo(tdo), .tdo_oe(tdo_oe), .pin_level(pin_level), .pin_data(pin_data),
		.pin_oe(pin_oe), .in_buf_en(in_buf_en));
	bsp_ctl_model bsp_ctl_model_inst (.tck(tck), .tap_in(tap_in), .tdo(tdo),
		.tdo_oe(tdo_oe));

	// Compares one observed value with its expectation and counts it.
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic give_verdict();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Loads an instruction, then lets the pin path settle in the system domain.
	task automatic load_ir(input logic [15:0] code);
		bsp_ctl_model_inst.scan(1'b1, 10, code, got);
		repeat (6) @(posedge sys_clk);
	endtask
	// Input buffers follow the output-only setting unless kept on.
	task automatic t_buffers();
		chk("in_buf_en", {12'h000, in_buf_en}, 16'h000C);
		keep_in_buf <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("in_buf_en kept", {12'h000, in_buf_en}, 16'h000F);
		keep_in_buf <= 1'b0;
	endtask
	// Reset, 0-1-1-0-0, then the captured pattern shifts out first.
	task automatic t_capture();
		bsp_ctl_model_inst.cyc(1'b0, 1'b1);
		load_ir(`BSP_IR_SAMPLE);
		chk("ir capture", got, 16'h02AA);
	endtask
	// Preload cells, then external test drives them onto the pins.
	task automatic t_extest();
		bsp_ctl_model_inst.scan(1'b0, 8, 16'h000A, got);
		chk("sampled pins", got, 16'h0004);
		load_ir(`BSP_IR_EXTEST);
		chk("pin_data", {12'h000, pin_data}, 16'h000A);
		chk("pin_oe", {12'h000, pin_oe}, 16'h000F);
	endtask
	// All-ones code gives a one-bit delay path and returns pins to the core.
	task automatic t_bypass();
		repeat (5) bsp_ctl_model_inst.cyc(1'b1, 1'b1);
		bsp_ctl_model_inst.cyc(1'b0, 1'b1);
		repeat (6) @(posedge sys_clk);
		chk("tms reset pin_oe", {12'h000, pin_oe}, 16'h0000);
		load_ir(`BSP_IR_BYPASS);
		chk("pin_oe core", {12'h000, pin_oe}, 16'h0000);
		bsp_ctl_model_inst.scan(1'b0, 8, 16'h00A5, got);
		chk("bypass", got, 16'h004A);
	endtask
	// External test is refused during programming and accepted after it.
	task automatic t_isp();
		load_ir(`BSP_IR_EXTEST);
		isp_busy <= 1'b1;
		repeat (4) @(posedge sys_clk);
		bsp_ctl_model_inst.scan(1'b0, 8, 16'h00A5, got);
		chk("isp forced", got, 16'h004A);
		load_ir(`BSP_IR_EXTEST);
		chk("isp pin_oe", {12'h000, pin_oe}, 16'h0000);
		bsp_ctl_model_inst.scan(1'b0, 8, 16'h00A5, got);
		chk("isp bypass", got, 16'h004A);
		isp_busy <= 1'b0;
		repeat (4) @(posedge sys_clk);
		load_ir(`BSP_IR_EXTEST);
		chk("after isp", {12'h000, pin_oe}, 16'h000F);
	endtask
	// System clock of 10 ns.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		#100000;
		fail_count++;
		give_verdict();
	end
	// Main sequence: reset both domains, then the scenarios.
	initial begin
		rstn = 1'b0;
		isp_busy = 1'b0;
		keep_in_buf = 1'b0;
		out_only = 4'h3;
		core_out = 4'h5;
		core_oe = 4'h0;
		pin_level = 4'h6;
		repeat (4) bsp_ctl_model_inst.cyc(1'b1, 1'b1);
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_buffers();
		t_capture();
		t_extest();
		t_bypass();
		t_isp();
		give_verdict();
	end
endmodule
